// ---- logic/gfs_pkg.sv ----
// Constants and types shared by the pin function select block.
package gfs_pkg;
    // Register indices; each index is one 32-bit word, byte address index*4.
    localparam logic [15:0] GFS_CFG_IDX   = 16'h781f;
    localparam logic [15:0] GFS_VALID_IDX = 16'h7827;
    localparam logic [15:0] GFS_CTRL_IDX  = 16'h7830;
    localparam logic [15:0] GFS_STAT_IDX  = 16'h7831;
    localparam logic [31:0] GFS_CFG_ADDR   = {14'h0, GFS_CFG_IDX, 2'h0};
    localparam logic [31:0] GFS_VALID_ADDR = {14'h0, GFS_VALID_IDX, 2'h0};
    localparam logic [31:0] GFS_CTRL_ADDR  = {14'h0, GFS_CTRL_IDX, 2'h0};
    localparam logic [31:0] GFS_STAT_ADDR  = {14'h0, GFS_STAT_IDX, 2'h0};
    // Configuration word fields and reset values.
    localparam int          GFS_CFG_DIR     = 15;
    localparam int          GFS_CFG_POL     = 10;
    localparam int          GFS_CFG_OD      = 9;
    localparam int          GFS_CFG_ENA     = 8;
    localparam int          GFS_CFG_FN_LO   = 4;
    localparam int          GFS_CFG_THR_LO  = 1;
    localparam logic [15:0] GFS_CFG_RESET   = 16'ha40a;
    localparam logic [15:0] GFS_VALID_RESET = 16'h0000;
    localparam logic [15:0] GFS_VALID_KEY   = 16'ha596;
    // Control word bits; command bits act as one-shot requests.
    localparam int GFS_CTRL_OUT   = 0;
    localparam int GFS_CTRL_DEV   = 1;
    localparam int GFS_CTRL_ON    = 2;
    localparam int GFS_CTRL_OFF   = 3;
    localparam int GFS_CTRL_SLEEP = 4;
    localparam int GFS_CTRL_WAKE  = 5;
    // Status word bits; the refused flag is write-one-to-clear.
    localparam int GFS_STAT_ON    = 0;
    localparam int GFS_STAT_SLEEP = 1;
    localparam int GFS_STAT_GOOD  = 2;
    localparam int GFS_STAT_PIN   = 3;
    localparam int GFS_STAT_REF   = 4;
    localparam int GFS_STAT_KEYOK = 5;
    // Timing, in nanoseconds, and the cycle counts derived from them.
    localparam int GFS_CYCLE_NS      = 10;
    localparam int GFS_DEB_NS        = 2000;
    localparam int GFS_LONG_DEB_NS   = 40000;
    localparam int GFS_CLK2M_HALF_NS = 250;
    localparam int GFS_DEB_CYC  = (GFS_DEB_NS + GFS_CYCLE_NS - 1) / GFS_CYCLE_NS;
    localparam int GFS_LONG_CYC =
        (GFS_LONG_DEB_NS + GFS_CYCLE_NS - 1) / GFS_CYCLE_NS;
    localparam int GFS_CLK2M_HALF = GFS_CLK2M_HALF_NS / GFS_CYCLE_NS;
    // Supply-good threshold code to millivolts.
    localparam logic [15:0] GFS_THR_BASE_MV = 16'd2800;
    localparam logic [15:0] GFS_THR_STEP_MV = 16'd100;
    localparam logic [15:0] GFS_HYST_MV     = 16'd50;
    // Power states of the device.
    typedef enum logic [1:0] {GFS_OFF, GFS_ON, GFS_SLEEP} gfs_pwr_t;
endpackage

// ---- logic/gfs_debounce.sv ----
// Input de-bounce filter with a normal and a long settling period.
`timescale 1ns/1ns
module gfs_debounce #(
    parameter int NORMAL_CYC = gfs_pkg::GFS_DEB_CYC,
    parameter int LONG_CYC   = gfs_pkg::GFS_LONG_CYC
) (
    // Clock and reset.
    input  wire logic clock,
    input  wire logic rst,
    // Raw level and period select.
    input  wire logic raw,
    input  wire logic use_long,
    // Filtered level.
    output logic      level
);
    localparam int CW = $clog2(LONG_CYC + 1);

    if (NORMAL_CYC < 1 || LONG_CYC < NORMAL_CYC) begin : g_chk
        $error("gfs_debounce: periods must be at least one and ordered");
    end

    typedef struct packed {
        logic          level;
        logic          prev;
        logic [CW-1:0] cnt;
    } gfs_deb_st_t;

    gfs_deb_st_t st;
    gfs_deb_st_t next_st;
    logic [CW-1:0] limit;

    // The level moves only after the raw input has held for a whole period.
    always_comb begin
        limit = use_long ? CW'(LONG_CYC) : CW'(NORMAL_CYC);
        next_st = st;
        next_st.prev = raw;
        if (raw != st.prev) begin
            next_st.cnt = '0;
        end else if (st.cnt < limit) begin
            next_st.cnt = st.cnt + CW'(1);
        end else begin
            next_st.level = raw;
        end
    end

    // State register.
    always_ff @(posedge clock) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign level = st.level;
endmodule

// ---- logic/gfs_supply_good.sv ----
// System supply good comparator with a coded rising threshold.
`timescale 1ns/1ns
module gfs_supply_good #(
    parameter logic [15:0] HYST_MV = gfs_pkg::GFS_HYST_MV
) (
    // Clock and reset.
    input  wire logic        clock,
    input  wire logic        rst,
    // Measured rail and threshold code.
    input  wire logic [15:0] rail_mv,
    input  wire logic [2:0]  thr_code,
    // Indication.
    output logic             good
);
    if (HYST_MV == 16'h0000) begin : g_chk
        $error("gfs_supply_good: hysteresis must be non-zero");
    end

    typedef struct packed {
        logic good;
    } gfs_sg_st_t;

    gfs_sg_st_t st;
    gfs_sg_st_t next_st;
    logic [15:0] thr_mv;

    // Rising trip is threshold plus hysteresis; it falls below the threshold.
    always_comb begin
        thr_mv = gfs_pkg::GFS_THR_BASE_MV
               + 16'(gfs_pkg::GFS_THR_STEP_MV * {13'h0, thr_code});
        next_st = st;
        if (st.good) begin
            next_st.good = rail_mv >= thr_mv;
        end else begin
            next_st.good = rail_mv >= 16'(thr_mv + HYST_MV);
        end
    end

    // State register.
    always_ff @(posedge clock) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign good = st.good;
endmodule

// ---- logic/gfs_pin_mux.sv ----
// Pin function select for general-purpose pin six, with APB registers.
`timescale 1ns/1ns
module gfs_pin_mux #(
    parameter int NORMAL_CYC = gfs_pkg::GFS_DEB_CYC,
    parameter int LONG_CYC   = gfs_pkg::GFS_LONG_CYC,
    parameter int CLK2M_HALF = gfs_pkg::GFS_CLK2M_HALF
) (
    // Clock and reset.
    input  wire logic        clock,
    input  wire logic        rst,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // The pin, as input, output and output enable.
    input  wire logic        pin_in,
    output logic             pin_out,
    output logic             pin_oe,
    // Sources for the output functions.
    input  wire logic        clk_32k,
    input  wire logic        dvs_done_1,
    input  wire logic        dvs_done_2,
    input  wire logic        ext_power_enable_1,
    input  wire logic        ext_power_enable_2,
    input  wire logic        converter_power_good,
    input  wire logic        aux_reset,
    input  wire logic [15:0] main_supply_rail,
    // Input function results.
    output logic             voltage_scale_select_1,
    output logic             voltage_scale_select_2,
    output logic             hw_enable_1,
    output logic             hw_enable_2,
    output logic             hw_control_1,
    output logic             hw_control_2,
    // Supply indication and power state.
    output logic             system_supply_good,
    output logic             power_on,
    output logic             power_sleep
);
    localparam int DW = $clog2(CLK2M_HALF + 1);

    if (CLK2M_HALF < 1) begin : g_chk
        $error("gfs_pin_mux: clock half period must be at least one cycle");
    end

    typedef struct packed {
        logic [15:0]      cfg;
        logic [15:0]      valid_word;
        logic             out_level;
        logic             dev_mode;
        logic             refused;
        gfs_pkg::gfs_pwr_t pwr;
        logic             change;
        logic             in_prev;
        logic [DW-1:0]    div;
        logic             clk_2m;
        logic             pready;
        logic             pslverr;
        logic [31:0]      prdata;
        logic             pin_out;
        logic             pin_oe;
        logic [5:0]       hw_in;
        logic             good;
        logic             pwr_on;
        logic             pwr_sleep;
    } gfs_top_st_t;

    gfs_top_st_t st;
    gfs_top_st_t next_st;

    logic       deb_level;
    logic       deb_long;
    logic       sg_good;
    logic [3:0] fn;
    logic       is_input;
    logic       enabled;
    logic       in_level;
    logic       in_rise;
    logic       in_edge;
    logic       wr;
    logic       setup_acc;
    logic       hit;
    logic       req_on;
    logic       req_off;
    logic       req_sleep;
    logic       req_wake;
    logic       req_toggle;
    logic       key_ok;
    logic       out_lvl;
    logic [2:0] hw_idx;
    logic [31:0] stat_word;

    // Pin input filter; the long period serves the long de-bounce codes.
    gfs_debounce #(
        .NORMAL_CYC (NORMAL_CYC),
        .LONG_CYC   (LONG_CYC)
    ) u_deb (
        .clock    (clock),
        .rst      (rst),
        .raw      (pin_in),
        .use_long (deb_long),
        .level    (deb_level)
    );

    // Supply good comparator driven by the threshold field.
    gfs_supply_good u_sg (
        .clock    (clock),
        .rst      (rst),
        .rail_mv  (main_supply_rail),
        .thr_code (st.cfg[gfs_pkg::GFS_CFG_THR_LO +: 3]),
        .good     (sg_good)
    );

    // Decode of the configuration word.
    assign fn       = st.cfg[gfs_pkg::GFS_CFG_FN_LO +: 4];
    assign is_input = st.cfg[gfs_pkg::GFS_CFG_DIR];
    assign enabled  = st.cfg[gfs_pkg::GFS_CFG_ENA];
    assign deb_long = is_input && (fn == 4'h0 || fn == 4'h4
                                   || fn == 4'he || fn == 4'hf);
    assign in_level = deb_level ^ ~st.cfg[gfs_pkg::GFS_CFG_POL];
    assign in_rise  = in_level && !st.in_prev;
    assign in_edge  = in_level != st.in_prev;
    assign key_ok   = st.valid_word == gfs_pkg::GFS_VALID_KEY;

    // APB strobes; a write lands on the edge that completes the access.
    assign setup_acc = psel && penable && !st.pready;
    assign wr        = psel && penable && st.pready && pwrite;
    assign hit       = paddr == gfs_pkg::GFS_CFG_ADDR
                    || paddr == gfs_pkg::GFS_VALID_ADDR
                    || paddr == gfs_pkg::GFS_CTRL_ADDR
                    || paddr == gfs_pkg::GFS_STAT_ADDR;

    // Power requests from software and from the pin's lower input codes.
    always_comb begin
        req_on     = wr && paddr == gfs_pkg::GFS_CTRL_ADDR
                     && pwdata[gfs_pkg::GFS_CTRL_ON];
        req_off    = wr && paddr == gfs_pkg::GFS_CTRL_ADDR
                     && pwdata[gfs_pkg::GFS_CTRL_OFF];
        req_sleep  = wr && paddr == gfs_pkg::GFS_CTRL_ADDR
                     && pwdata[gfs_pkg::GFS_CTRL_SLEEP];
        req_wake   = wr && paddr == gfs_pkg::GFS_CTRL_ADDR
                     && pwdata[gfs_pkg::GFS_CTRL_WAKE];
        req_toggle = 1'b0;
        if (is_input && enabled) begin
            unique case (fn)
                4'h2: begin
                    req_toggle = in_rise;
                end
                4'h3, 4'h4: begin
                    req_sleep = req_sleep || in_rise;
                    req_wake  = req_wake || (in_edge && !in_level);
                end
                4'h5: begin
                    req_sleep = req_sleep || in_rise;
                end
                4'h6: begin
                    req_on = req_on || in_rise;
                end
                4'h7: begin
                    req_off = req_off || in_rise;
                end
                default: begin
                    req_toggle = 1'b0;
                end
            endcase
        end
    end

    // Output function selection, before polarity and drive mode.
    always_comb begin
        unique case (fn)
            4'h0: out_lvl = st.out_level;
            4'h1: out_lvl = clk_32k;
            4'h2: out_lvl = st.pwr == gfs_pkg::GFS_ON;
            4'h3: out_lvl = st.pwr == gfs_pkg::GFS_SLEEP;
            4'h4: out_lvl = st.change;
            4'h5, 4'h6, 4'h7: out_lvl = 1'b0;
            4'h8: out_lvl = dvs_done_1;
            4'h9: out_lvl = dvs_done_2;
            4'ha: out_lvl = ext_power_enable_1;
            4'hb: out_lvl = ext_power_enable_2;
            4'hc: out_lvl = sg_good;
            4'hd: out_lvl = converter_power_good;
            4'he: out_lvl = st.clk_2m;
            4'hf: out_lvl = aux_reset;
        endcase
    end

    // Input codes 8 to 15 map onto six hardware input lines.
    always_comb begin
        if (fn < 4'hc) begin
            hw_idx = {1'b0, fn[1:0]};
        end else begin
            hw_idx = 3'h4 + {2'h0, fn[0]};
        end
    end

    // Status word seen by software.
    always_comb begin
        stat_word = '0;
        stat_word[gfs_pkg::GFS_STAT_ON]    = st.pwr == gfs_pkg::GFS_ON;
        stat_word[gfs_pkg::GFS_STAT_SLEEP] = st.pwr == gfs_pkg::GFS_SLEEP;
        stat_word[gfs_pkg::GFS_STAT_GOOD]  = sg_good;
        stat_word[gfs_pkg::GFS_STAT_PIN]   = deb_level;
        stat_word[gfs_pkg::GFS_STAT_REF]   = st.refused;
        stat_word[gfs_pkg::GFS_STAT_KEYOK] = key_ok;
    end

    // Next state of the whole block.
    always_comb begin
        next_st = st;
        next_st.in_prev = in_level;
        next_st.change  = 1'b0;

        // Bus answer: one wait state, then ready with data or error.
        next_st.pready  = setup_acc;
        next_st.pslverr = setup_acc && !hit;
        if (setup_acc && !(pwrite && hit)) begin
            if (paddr == gfs_pkg::GFS_CFG_ADDR) begin
                next_st.prdata = {16'h0, st.cfg};
            end else if (paddr == gfs_pkg::GFS_VALID_ADDR) begin
                next_st.prdata = {16'h0, st.valid_word};
            end else if (paddr == gfs_pkg::GFS_CTRL_ADDR) begin
                next_st.prdata = {30'h0, st.dev_mode, st.out_level};
            end else if (paddr == gfs_pkg::GFS_STAT_ADDR) begin
                next_st.prdata = stat_word;
            end else begin
                next_st.prdata = '0;
            end
        end

        // Register writes; command bits are not stored.
        if (wr && paddr == gfs_pkg::GFS_CFG_ADDR) begin
            next_st.cfg = pwdata[15:0];
        end
        if (wr && paddr == gfs_pkg::GFS_VALID_ADDR) begin
            next_st.valid_word = pwdata[15:0];
        end
        if (wr && paddr == gfs_pkg::GFS_CTRL_ADDR) begin
            next_st.out_level = pwdata[gfs_pkg::GFS_CTRL_OUT];
            next_st.dev_mode  = pwdata[gfs_pkg::GFS_CTRL_DEV];
        end
        if (wr && paddr == gfs_pkg::GFS_STAT_ADDR
            && pwdata[gfs_pkg::GFS_STAT_REF]) begin
            next_st.refused = 1'b0;
        end

        // Power state; a new refusal below wins over a clear above.
        unique case (st.pwr)
            gfs_pkg::GFS_OFF: begin
                if (req_on || req_toggle) begin
                    if (st.dev_mode && !key_ok) begin
                        next_st.refused = 1'b1;
                    end else begin
                        next_st.pwr = gfs_pkg::GFS_ON;
                    end
                end
            end
            gfs_pkg::GFS_ON: begin
                if (req_off || req_toggle) begin
                    next_st.pwr = gfs_pkg::GFS_OFF;
                end else if (req_sleep) begin
                    next_st.pwr = gfs_pkg::GFS_SLEEP;
                end
            end
            gfs_pkg::GFS_SLEEP: begin
                if (req_off || req_toggle) begin
                    next_st.pwr = gfs_pkg::GFS_OFF;
                end else if (req_wake) begin
                    next_st.pwr = gfs_pkg::GFS_ON;
                end
            end
            default: begin
                next_st.pwr = gfs_pkg::GFS_OFF;
            end
        endcase
        next_st.change    = next_st.pwr != st.pwr;
        next_st.pwr_on    = next_st.pwr == gfs_pkg::GFS_ON;
        next_st.pwr_sleep = next_st.pwr == gfs_pkg::GFS_SLEEP;

        // Free running 2 MHz clock, a toggle every half period.
        if (st.div >= DW'(CLK2M_HALF - 1)) begin
            next_st.div    = '0;
            next_st.clk_2m = !st.clk_2m;
        end else begin
            next_st.div = st.div + DW'(1);
        end

        // Pin drive; open drain only ever pulls low, disabled pins float.
        if (enabled && !is_input) begin
            if (st.cfg[gfs_pkg::GFS_CFG_OD]) begin
                next_st.pin_out = 1'b0;
                next_st.pin_oe  = !(out_lvl ^ ~st.cfg[gfs_pkg::GFS_CFG_POL]);
            end else begin
                next_st.pin_out = out_lvl ^ ~st.cfg[gfs_pkg::GFS_CFG_POL];
                next_st.pin_oe  = 1'b1;
            end
        end else begin
            next_st.pin_out = 1'b0;
            next_st.pin_oe  = 1'b0;
        end

        // Input functions; lines not selected rest low.
        next_st.hw_in = '0;
        if (enabled && is_input && fn[3]) begin
            next_st.hw_in[hw_idx] = in_level;
        end
        next_st.good = sg_good;
    end

    // State register; the power state starts off.
    always_ff @(posedge clock) begin
        if (rst) begin
            st            <= '0;
            st.cfg        <= gfs_pkg::GFS_CFG_RESET;
            st.valid_word <= gfs_pkg::GFS_VALID_RESET;
            st.pwr        <= gfs_pkg::GFS_OFF;
        end else begin
            st <= next_st;
        end
    end

    // Outputs come straight from the state register.
    assign prdata                 = st.prdata;
    assign pready                 = st.pready;
    assign pslverr                = st.pslverr;
    assign pin_out                = st.pin_out;
    assign pin_oe                 = st.pin_oe;
    assign voltage_scale_select_1 = st.hw_in[0];
    assign voltage_scale_select_2 = st.hw_in[1];
    assign hw_enable_1            = st.hw_in[2];
    assign hw_enable_2            = st.hw_in[3];
    assign hw_control_1           = st.hw_in[4];
    assign hw_control_2           = st.hw_in[5];
    assign system_supply_good     = st.good;
    assign power_on               = st.pwr_on;
    assign power_sleep            = st.pwr_sleep;
endmodule

// ---- tb/gfs_pin_mux_asserts.sv ----
// Port-level checks for the pin function select block.
`timescale 1ns/1ns
module gfs_pin_mux_asserts (
    // Clock and reset.
    input wire logic        clock,
    input wire logic        rst,
    // APB.
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Pin, supply and state.
    input wire logic        pin_oe,
    input wire logic [15:0] main_supply_rail,
    input wire logic        system_supply_good,
    input wire logic        power_on,
    input wire logic        power_sleep
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    // Setup and first access cycle of a transfer.
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence access_s;
        psel && penable;
    endsequence
    ready_one_wait_a: assert property (setup_s ##1 access_s |->
        !pready ##1 pready) else $error("pready wait state");
    ready_single_a: assert property (pready |=> !pready)
        else $error("pready too long");
    slverr_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    slverr_data_a: assert property (pslverr |-> prdata == 32'h0)
        else $error("prdata not zero");
    state_mutex_a: assert property (!(power_on && power_sleep))
        else $error("on and sleep both shown");
    sleep_from_on_a: assert property ($rose(power_sleep) |->
        $past(power_on)) else $error("sleep not from on");
    good_rise_a: assert property ($rose(system_supply_good) |->
        $past(main_supply_rail, 2) >= 16'd2850)
        else $error("good rose too low");
    good_fall_a: assert property ($fell(system_supply_good) |->
        $past(main_supply_rail, 2) < 16'd3500)
        else $error("good fell too high");
    reset_clears_a: assert property ($fell(rst) |->
        !power_on && !pin_oe && !pready) else $error("reset not cleared");
endmodule
bind gfs_pin_mux gfs_pin_mux_asserts u_gfs_pin_mux_asserts (
    .clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_oe(pin_oe),
    .main_supply_rail(main_supply_rail),
    .system_supply_good(system_supply_good),
    .power_on(power_on), .power_sleep(power_sleep));

// ---- tb/gfs_far_side.sv ----
// Far-side model: the slow oscillator behind one output code.
`timescale 1ns/1ns
module gfs_far_side #(
    parameter int HALF_32K = 20
) (
    // Clock.
    input  wire logic clock,
    // Slow clock.
    output logic      clk_32k
);
    logic slow = 1'b0;
    int   cnt  = 0;
    // The slow clock is scaled down so that whole periods fit a short run.
    always @(posedge clock) begin
        cnt <= (cnt == HALF_32K - 1) ? 0 : cnt + 1;
        if (cnt == HALF_32K - 1) begin
            slow <= ~slow;
        end
    end
    // Divider output.
    assign clk_32k = slow;
endmodule

// ---- tb/gfs_pin_mux_tb_top.sv ----
// Self-checking bench for the pin function select block.
`timescale 1ns/1ns
module gfs_pin_mux_tb_top;
    localparam int NCYC = 3;
    localparam int LCYC = 8;
    localparam int HALF32 = 20;
    localparam logic [31:0] CFG = gfs_pkg::GFS_CFG_ADDR;
    localparam logic [31:0] VLD = gfs_pkg::GFS_VALID_ADDR;
    localparam logic [31:0] CTL = gfs_pkg::GFS_CTRL_ADDR;
    localparam logic [31:0] STA = gfs_pkg::GFS_STAT_ADDR;
    logic        clock;
    logic        rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        pin_in;
    logic        pin_out;
    logic        pin_oe;
    logic        clk_32k;
    logic        src;
    logic [15:0] rail;
    logic [5:0]  fn_out;
    logic        good;
    logic        power_on;
    logic        power_sleep;
    int          n_fail = 0;
    int          checks = 0;

    gfs_pin_mux #(.NORMAL_CYC(NCYC), .LONG_CYC(LCYC)) u_gfs_pin_mux (
        .clock(clock), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .clk_32k(clk_32k),
        .dvs_done_1(src), .dvs_done_2(src), .ext_power_enable_1(src),
        .ext_power_enable_2(src), .converter_power_good(src),
        .aux_reset(src), .main_supply_rail(rail),
        .voltage_scale_select_1(fn_out[0]),
        .voltage_scale_select_2(fn_out[1]),
        .hw_enable_1(fn_out[2]), .hw_enable_2(fn_out[3]),
        .hw_control_1(fn_out[4]), .hw_control_2(fn_out[5]),
        .system_supply_good(good), .power_on(power_on),
        .power_sleep(power_sleep));
    gfs_far_side #(.HALF_32K(HALF32)) u_gfs_far_side (
        .clock(clock), .clk_32k(clk_32k));

    // Free-running 100 MHz clock.
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic stop_test;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Wait n edges, then sample at the falling edge.
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        @(negedge clock);
    endtask

    // One APB transfer, held until pready is sampled high.
    task automatic apb(input logic wr, input logic [31:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        int n;
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge clock);
        if (pready !== 1'b1) begin
            n_fail++;
            stop_test();
        end
        r = prdata;
        cmp(pslverr, !(a inside {CFG, VLD, CTL, STA}));
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask

    task automatic rdc(input logic [31:0] a, input logic [31:0] m,
                       input logic [31:0] e);
        logic [31:0] r;
        apb(1'b0, a, 32'h0, r);
        cmp(r & m, e);
    endtask

    function automatic logic [31:0] cfg(input logic dir,
        input logic [3:0] fn, input logic [2:0] thr);
        return {16'h0, dir, 7'h25, fn, thr, 1'b0};
    endfunction

    // Reset values, an unmapped access and a plain read-back.
    task automatic t_regs;
        rdc(CFG, '1, 32'h0000a40a);
        rdc(VLD, '1, 32'h0);
        wr(32'h10, 32'hffffffff);
        rdc(32'h10, '1, 32'h0);
        wr(VLD, 32'h1234);
        rdc(VLD, '1, 32'h1234);
    endtask

    // Every output code, with all sources high and power off.
    task automatic t_outputs;
        logic [15:0] exp = 16'hbf01;
        logic        prev;
        int          c, k, t;
        @(posedge clock);
        src  <= 1'b1;
        rail <= 16'd3400;
        wr(CTL, 32'h1);
        for (c = 0; c < 16; c++) begin
            wr(CFG, cfg(1'b0, c[3:0], 3'h5));
            cyc(4);
            cmp(pin_oe, 1'b1);
            if (c == 1 || c == 14) begin
                t = 0;
                prev = pin_out;
                for (k = 0; k < 100; k++) begin
                    @(negedge clock);
                    t += (pin_out !== prev);
                    prev = pin_out;
                end
                cmp(t, 100 / (c == 1 ? HALF32 : 25));
            end else begin
                cmp(pin_out, exp[c]);
            end
        end
    endtask

    // Rising trip at threshold plus margin, held at the threshold, falling one below it.
    task automatic t_supply;
        logic [2:0]  codes [3] = '{3'h0, 3'h5, 3'h7};
        logic [15:0] lim;
        logic [15:0] v [5];
        int          i, j;
        for (i = 0; i < 3; i++) begin
            lim = 16'd2800 + 16'd100 * codes[i];
            v = '{16'd2000, lim + 16'd49, lim + 16'd50, lim, lim - 16'd1};
            wr(CFG, cfg(1'b1, 4'h0, codes[i]));
            for (j = 0; j < 5; j++) begin
                @(posedge clock);
                rail <= v[j];
                cyc(6);
                cmp(good, j == 2 || j == 3);
            end
        end
    endtask

    // Development-mode power-on refused, then accepted with the key.
    task automatic t_dev;
        wr(CTL, 32'h2);
        wr(CTL, 32'h6);
        cyc(3);
        cmp(power_on, 1'b0);
        rdc(STA, 32'h33, 32'h10);
        wr(STA, 32'h10);
        wr(VLD, 32'ha596);
        rdc(STA, 32'h30, 32'h20);
        wr(CTL, 32'h6);
        cyc(3);
        cmp(power_on, 1'b1);
        wr(CTL, 32'h12);
        cyc(3);
        cmp({power_on, power_sleep}, 2'h1);
        wr(CTL, 32'ha);
        cyc(3);
        cmp({power_on, power_sleep}, 2'h0);
    endtask

    // Input codes 8 to 15: normal filter passes early, long one later.
    task automatic t_inputs;
        int c;
        int idx;
        for (c = 8; c < 16; c++) begin
            idx = (c < 14) ? c - 8 : c - 10;
            @(posedge clock);
            pin_in <= 1'b0;
            wr(CFG, cfg(1'b1, c[3:0], 3'h5));
            cyc(LCYC + 6);
            cmp({pin_oe, fn_out}, 7'h0);
            @(posedge clock);
            pin_in <= 1'b1;
            cyc(NCYC + 6);
            cmp(fn_out, (c < 14) ? 6'h1 << idx : 6'h0);
            cyc(LCYC - NCYC + 3);
            cmp(fn_out, 6'h1 << idx);
        end
    endtask

    // Main sequence.
    initial begin
        rst       = 1'b1;
        psel      = 1'b0;
        penable   = 1'b0;
        pwrite    = 1'b0;
        paddr     = 32'h0;
        pwdata    = 32'h0;
        pin_in    = 1'b0;
        src       = 1'b0;
        rail      = 16'd2000;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        t_regs();
        t_outputs();
        t_supply();
        t_dev();
        t_inputs();
        stop_test();
    end

    // Cuts a hang short.
    initial begin
        repeat (100000) @(posedge clock);
        n_fail++;
        stop_test();
    end
endmodule
